// ===== core/rjb_exec.sv
// Execute unit for the no-overflow jump, nonzero jump, unconditional jump and single-bit set.
// Assumes fetch, flags, bank pointer and data memory all run on clk_sys_i; memory read is combinational.
`timescale 1ns/10ps

module rjb_exec
  import rjb_pkg::*;
(
  input  wire logic                    clk_sys_i,
  input  wire logic                    rst_i,
  // Instruction fetch
  input  wire logic [rjb_pkg::IW_W-1:0] instr_i,
  input  wire logic                    instr_valid_i,
  output logic                         instr_ack_o,
  // Program counter, already incremented past the current instruction
  input  wire logic [rjb_pkg::PC_W-1:0] pc_i,
  output logic                         pc_load_o,
  output logic [rjb_pkg::PC_W-1:0]      pc_target_o,
  // Flags and bank state, read only
  input  wire logic                    overflow_i,
  input  wire logic                    zero_i,
  input  wire logic [3:0]              ram_bank_pointer_i,
  input  wire logic [rjb_pkg::DA_W-1:0] index_base_i,
  // Data memory
  output logic [rjb_pkg::DA_W-1:0]      mem_addr_o,
  output logic                         mem_rd_o,
  input  wire logic [7:0]              mem_rdata_i,
  output logic                         mem_wr_o,
  output logic [7:0]                   mem_wdata_o,
  output logic                         quarter_q1_o,
  // APB slave
  input  wire logic [rjb_pkg::APB_AW-1:0] paddr,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [31:0]             pwdata,
  output logic [31:0]                  prdata,
  output logic                         pready,
  output logic                         pslverr
);
  import rjb_pkg::*;

  rjb_quarter_type       q_q, q_d;
  rjb_state_type         st_q, st_d;
  logic [IW_W-1:0]       ir_q, ir_d;
  logic                  held_q, held_d;
  logic [DA_W-1:0]       addr_q, addr_d;
  logic                  rd_q, rd_d;
  logic                  wr_q, wr_d;
  logic [7:0]            wdata_q, wdata_d;
  logic                  load_q, load_d;
  logic [PC_W-1:0]       tgt_q, tgt_d;
  logic                  take_q, take_d;
  rjb_kind_type          kind_q, kind_d;
  logic [1:0]            ctrl_q, ctrl_d;
  logic [15:0]           jcnt_q, jcnt_d;
  logic [15:0]           bcnt_q, bcnt_d;
  logic [31:0]           rdat_q, rdat_d;
  logic                  err_q, err_d;

  rjb_kind_type          kind;
  logic [PC_W-1:0]       offset2;
  logic [7:0]            fsel;
  logic [7:0]            bit_mask;
  logic                  accept;

  // Decode of the held instruction
  always_comb
  begin
    kind = K_OTHER;
    if (ir_q[IW_W-1:OPC8_LSB] == OPC_JUMP_IF_NO_OVERFLOW)
      kind = K_NOV;
    else if (ir_q[IW_W-1:OPC8_LSB] == OPC_JUMP_IF_NONZERO)
      kind = K_NZ;
    else if (ir_q[IW_W-1:OPC5_LSB] == OPC_RELATIVE_JUMP)
      kind = K_ALWAYS;
    else if (ir_q[IW_W-1:OPC4_LSB] == OPC_SET_SINGLE_BIT)
      kind = K_BITSET;
  end

  // Signed offset doubled and sign extended to the PC width
  always_comb
  begin
    if (kind == K_ALWAYS)
      offset2 = {{(PC_W-LONG_N_W-1){ir_q[LONG_N_W-1]}}, ir_q[LONG_N_W-1:0], 1'b0};
    else
      offset2 = {{(PC_W-SHORT_N_W-1){ir_q[SHORT_N_W-1]}}, ir_q[SHORT_N_W-1:0], 1'b0};
  end

  assign fsel     = ir_q[7:0];
  assign bit_mask = 8'h01 << ir_q[BIT_LSB +: 3];

  // An instruction is only consumed in Q1 of a cycle that is not a flush cycle
  assign accept = (q_q == Q1) && (st_q == ST_EXEC) && ctrl_q[CTRL_EXEC_EN] && instr_valid_i;

  // Quarter phases, instruction cycle and flush state
  always_comb
  begin
    q_d     = q_q;
    st_d    = st_q;
    ir_d    = ir_q;
    held_d  = held_q;
    addr_d  = addr_q;
    rd_d    = 1'b0;
    wr_d    = 1'b0;
    wdata_d = wdata_q;
    load_d  = 1'b0;
    tgt_d   = tgt_q;
    take_d  = take_q;
    kind_d  = kind_q;
    jcnt_d  = jcnt_q;
    bcnt_d  = bcnt_q;
    case (q_q)
      Q1:
      begin
        q_d    = Q2;
        held_d = accept;
        take_d = 1'b0;
        if (accept)
          ir_d = instr_i;
      end
      Q2:
      begin
        q_d = Q3;
        if (held_q)
        begin
          kind_d = kind;
          if (kind == K_BITSET)
          begin
            rd_d = 1'b1;
            if (!ir_q[BANK_SEL] && ctrl_q[CTRL_EXT_EN] && (fsel <= INDEXED_MAX_F))
              addr_d = index_base_i + {4'h0, fsel};
            else if (ir_q[BANK_SEL])
              addr_d = {ram_bank_pointer_i, fsel};
            else if (fsel < ACCESS_SPLIT)
              addr_d = {ACCESS_LO_BNK, fsel};
            else
              addr_d = {ACCESS_HI_BNK, fsel};
          end
        end
      end
      Q3:
      begin
        q_d = Q4;
        if (held_q)
        begin
          // Flags are only sampled, never written back
          tgt_d = pc_i + offset2;
          case (kind_q)
            K_NOV:    take_d = !overflow_i;
            K_NZ:     take_d = !zero_i;
            K_ALWAYS: take_d = 1'b1;
            default:  take_d = 1'b0;
          endcase
          load_d = take_d;
          if (kind_q == K_BITSET)
          begin
            wdata_d = mem_rdata_i | bit_mask;
            wr_d    = 1'b1;
            bcnt_d  = bcnt_q + 16'h0001;
          end
          if (take_d)
            jcnt_d = jcnt_q + 16'h0001;
        end
      end
      Q4:
      begin
        q_d    = Q1;
        held_d = 1'b0;
        // A taken jump spends the next whole cycle doing nothing
        st_d   = take_q ? ST_FLUSH : ST_EXEC;
      end
      default:
      begin
        q_d = Q1;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      q_q     <= Q1;
      st_q    <= ST_EXEC;
      ir_q    <= 16'h0000;
      held_q  <= 1'b0;
      addr_q  <= 12'h000;
      rd_q    <= 1'b0;
      wr_q    <= 1'b0;
      wdata_q <= 8'h00;
      load_q  <= 1'b0;
      tgt_q   <= 21'h000000;
      take_q  <= 1'b0;
      kind_q  <= K_NONE;
      jcnt_q  <= 16'h0000;
      bcnt_q  <= 16'h0000;
    end
    else
    begin
      q_q     <= q_d;
      st_q    <= st_d;
      ir_q    <= ir_d;
      held_q  <= held_d;
      addr_q  <= addr_d;
      rd_q    <= rd_d;
      wr_q    <= wr_d;
      wdata_q <= wdata_d;
      load_q  <= load_d;
      tgt_q   <= tgt_d;
      take_q  <= take_d;
      kind_q  <= kind_d;
      jcnt_q  <= jcnt_d;
      bcnt_q  <= bcnt_d;
    end
  end

  assign instr_ack_o  = accept;
  assign pc_load_o    = load_q;
  assign pc_target_o  = tgt_q;
  assign mem_addr_o   = addr_q;
  assign mem_rd_o     = rd_q;
  assign mem_wr_o     = wr_q;
  assign mem_wdata_o  = wdata_q;
  assign quarter_q1_o = (q_q == Q1);

  // APB: read data is latched in the setup phase so every access completes with no wait
  always_comb
  begin
    ctrl_d = ctrl_q;
    rdat_d = rdat_q;
    err_d  = err_q;
    if (psel && !penable)
    begin
      rdat_d = 32'h0000_0000;
      err_d  = 1'b0;
      if (paddr == REG_CTRL)
        rdat_d = {30'h0, ctrl_q};
      else if (paddr == REG_STATUS)
        rdat_d = {26'h0, kind_q, take_q, held_q, st_q == ST_FLUSH};
      else if (paddr == REG_JUMP_CNT)
        rdat_d = {16'h0, jcnt_q};
      else if (paddr == REG_BITSET_CNT)
        rdat_d = {16'h0, bcnt_q};
      else
        err_d = 1'b1;
    end
    if (psel && penable && pwrite && (paddr == REG_CTRL))
      ctrl_d = pwdata[1:0];
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      ctrl_q <= CTRL_RESET;
      rdat_q <= 32'h0000_0000;
      err_q  <= 1'b0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      rdat_q <= rdat_d;
      err_q  <= err_d;
    end
  end

  assign prdata  = rdat_q;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && err_q;

endmodule

// ===== core/rjb_pkg.sv
// Constants shared by the relative-jump and bit-set execute unit.
// Assumes a 16-bit instruction word, 21-bit byte program counter and 12-bit data space.
package rjb_pkg;

  localparam int PC_W   = 21;
  localparam int DA_W   = 12;
  localparam int IW_W   = 16;
  localparam int APB_AW = 8;

  // Opcode patterns
  localparam logic [7:0] OPC_JUMP_IF_NO_OVERFLOW = 8'he5;
  localparam logic [7:0] OPC_JUMP_IF_NONZERO     = 8'he1;
  localparam logic [4:0] OPC_RELATIVE_JUMP       = 5'h1a;
  localparam logic [3:0] OPC_SET_SINGLE_BIT      = 4'h8;

  // Field positions inside the instruction word
  localparam int OPC8_LSB   = 8;
  localparam int OPC5_LSB   = 11;
  localparam int OPC4_LSB   = 12;
  localparam int BIT_LSB    = 9;
  localparam int BANK_SEL   = 8;
  localparam int SHORT_N_W  = 8;
  localparam int LONG_N_W   = 11;

  // Data addressing
  localparam logic [7:0] INDEXED_MAX_F = 8'h5f;
  localparam logic [7:0] ACCESS_SPLIT  = 8'h80;
  localparam logic [3:0] ACCESS_LO_BNK = 4'h0;
  localparam logic [3:0] ACCESS_HI_BNK = 4'hf;

  // Register map (byte addresses)
  localparam logic [APB_AW-1:0] REG_CTRL       = 8'h00;
  localparam logic [APB_AW-1:0] REG_STATUS     = 8'h04;
  localparam logic [APB_AW-1:0] REG_JUMP_CNT   = 8'h08;
  localparam logic [APB_AW-1:0] REG_BITSET_CNT = 8'h0c;

  localparam int CTRL_EXEC_EN = 0;
  localparam int CTRL_EXT_EN  = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  typedef enum logic [1:0] {Q1, Q2, Q3, Q4} rjb_quarter_type;
  typedef enum logic {ST_EXEC, ST_FLUSH} rjb_state_type;
  typedef enum logic [2:0] {K_NONE, K_NOV, K_NZ, K_ALWAYS, K_BITSET, K_OTHER} rjb_kind_type;

endpackage

// ===== tb/relative_jump_and_bit_set_exec_tb.sv
// Testbench: each instruction kind through the unit, checking jumps, targets and write-back.
// Assumes zero-wait APB and the data memory partner.
`timescale 1ns/10ps
module relative_jump_and_bit_set_exec_tb;
  import rjb_pkg::*;
  typedef struct packed {logic [15:0] ins; logic [2:0] vzx; logic [20:0] off; logic [11:0] a; logic [7:0] d;}
    rjb_case_type;
  logic        clk_sys_i = 1'h0, rst_i = 1'h1, instr_valid_i = 1'h0, overflow_i = 1'h0, zero_i = 1'h0;
  logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0, e;
  logic [15:0] instr_i = 16'h0;
  logic [20:0] pc_i = 21'h001000, pc_target_o, tgt, et;
  logic [11:0] index_base_i = 12'h200, mem_addr_o, wa;
  logic [3:0]  ram_bank_pointer_i = 4'h3;
  logic [7:0]  paddr = 8'h0, mem_rdata_i, mem_wdata_o, wd;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic        instr_ack_o, pc_load_o, mem_rd_o, mem_wr_o, quarter_q1_o, pready, pslverr;
  int          err_count = 0, num_checks = 0, cyc = 0, nl, nw, na;
  rjb_case_type tc [13] = '{
    '{16'he505, 3'h0, 21'h00000a, 12'h0, 8'h0}, '{16'he580, 3'h4, 21'h0, 12'h0, 8'h0},
    '{16'he580, 3'h2, 21'h1fff00, 12'h0, 8'h0}, '{16'he17f, 3'h4, 21'h0000fe, 12'h0, 8'h0},
    '{16'he110, 3'h2, 21'h0, 12'h0, 8'h0}, '{16'hd400, 3'h6, 21'h1ff800, 12'h0, 8'h0},
    '{16'hd3ff, 3'h6, 21'h0007fe, 12'h0, 8'h0}, '{16'he600, 3'h0, 21'h0, 12'h0, 8'h0},
    '{16'h8f20, 3'h0, 21'h0, 12'h320, 8'ha0}, '{16'h8090, 3'h0, 21'h0, 12'hf90, 8'h91},
    '{16'h8410, 3'h0, 21'h0, 12'h010, 8'h14}, '{16'h8a5f, 3'h1, 21'h0, 12'h25f, 8'h7f},
    '{16'h8060, 3'h1, 21'h0, 12'h060, 8'h61}};
  rjb_exec i_dut (.clk_sys_i, .rst_i, .instr_i, .instr_valid_i, .instr_ack_o, .pc_i, .pc_load_o, .pc_target_o,
    .overflow_i, .zero_i, .ram_bank_pointer_i, .index_base_i, .mem_addr_o, .mem_rd_o, .mem_rdata_i, .mem_wr_o,
    .mem_wdata_o, .quarter_q1_o, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr);
  rjb_data_mem i_mem (.clk_sys_i, .addr_i(mem_addr_o), .rd_i(mem_rd_o), .wr_i(mem_wr_o), .wdata_i(mem_wdata_o),
    .rdata_o(mem_rdata_i));
  initial
    forever #25 clk_sys_i = ~clk_sys_i;
  task automatic results;
    if (err_count == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
    @(posedge clk_sys_i);
    penable <= 1'h1;
    do @(posedge clk_sys_i); while (pready !== 1'h1);
    {r, e} = {prdata, pslverr};
    {psel, penable} <= 2'h0;
  endtask
  // Offers one word, then watches two instruction cycles for strobes
  task automatic run(input rjb_case_type c);
    {nl, nw, na} = 96'h0;
    {instr_i, overflow_i, zero_i, instr_valid_i} <= {c.ins, c.vzx[2:1], 1'h1};
    do @(posedge clk_sys_i); while (instr_ack_o !== 1'h1);
    // Keep offering a do-nothing word so a flush cycle that takes it is caught
    instr_i <= 16'hffff;
    repeat (8)
    begin
      @(posedge clk_sys_i);
      na += int'(instr_ack_o === 1'h1);
      nl += int'(pc_load_o === 1'h1);
      nw += int'(mem_wr_o === 1'h1);
      if (pc_load_o === 1'h1)
        tgt = pc_target_o;
      if (mem_wr_o === 1'h1)
        {wa, wd} = {mem_addr_o, mem_wdata_o};
    end
    instr_valid_i <= 1'h0;
  endtask
  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (cyc > 2000)
    begin
      err_count++;
      results();
    end
  end
  initial
  begin
    repeat (3) @(posedge clk_sys_i);
    rst_i <= 1'h0;
    apb(1'h0, REG_CTRL, 32'h0);
    chk(r, 32'h0);
    foreach (tc[i])
    begin
      apb(1'h1, REG_CTRL, {30'h0, tc[i].vzx[0], 1'h1});
      run(tc[i]);
      et = pc_i + tc[i].off;
      chk(32'(nl), {31'h0, |tc[i].off});
      chk(32'(nw), {31'h0, |tc[i].d});
      chk(32'(na), |tc[i].off ? 32'h1 : 32'h2);
      if (nl > 0)
        chk({11'h0, tgt}, {11'h0, et});
      if (nw > 0)
        chk({12'h0, wa, wd}, {12'h0, tc[i].a, tc[i].d});
    end
    apb(1'h1, REG_JUMP_CNT, 32'hff);
    apb(1'h0, REG_JUMP_CNT, 32'h0);
    chk(r, 32'h5);
    apb(1'h0, REG_BITSET_CNT, 32'h0);
    chk(r, 32'h5);
    apb(1'h0, REG_STATUS, 32'h0);
    chk(r, 32'h28);
    apb(1'h0, REG_CTRL, 32'h0);
    chk(r, 32'h3);
    apb(1'h0, 8'h10, 32'h0);
    chk({r[30:0], e}, 32'h1);
    results();
  end
endmodule
bind rjb_exec rjb_exec_checker i_chk (.clk_sys_i, .rst_i, .instr_i, .instr_ack_o, .quarter_q1_o, .pc_i, .pc_load_o,
  .pc_target_o, .overflow_i, .zero_i, .ram_bank_pointer_i, .mem_addr_o, .mem_rd_o, .mem_rdata_i, .mem_wr_o,
  .mem_wdata_o);

// ===== tb/rjb_data_mem.sv
// Data memory partner: combinational read, write on the strobe edge.
// Assumes the unit's clock; each byte starts equal to its low address byte.
`timescale 1ns/10ps
module rjb_data_mem
  import rjb_pkg::*;
(
  input  wire logic                     clk_sys_i,
  input  wire logic [rjb_pkg::DA_W-1:0] addr_i,
  input  wire logic                     rd_i,
  input  wire logic                     wr_i,
  input  wire logic [7:0]               wdata_i,
  output logic [7:0]                    rdata_o
);
  logic [7:0] ram [4096];
  logic [7:0] last_q = 8'h00;
  initial
    for (int i = 0; i < 4096; i++)
      ram[i] = i[7:0];
  always @(posedge clk_sys_i)
  begin
    if (wr_i)
      ram[addr_i] <= wdata_i;
    if (rd_i)
      last_q <= ram[addr_i];
  end
  // Outside a read the bus shows junk so a stale sample is caught
  assign rdata_o = rd_i ? ram[addr_i] : ~last_q;
endmodule

// ===== tb/rjb_exec_assertions.sv
// Checker for the execute unit: quarter timing, jump decisions, targets and bit-set write-back.
// Assumes it is bound to rjb_exec and sees only that module's ports.
`timescale 1ns/10ps
module rjb_exec_checker
  import rjb_pkg::*;
(
  input wire logic                     clk_sys_i,
  input wire logic                     rst_i,
  input wire logic [rjb_pkg::IW_W-1:0] instr_i,
  input wire logic                     instr_ack_o,
  input wire logic                     quarter_q1_o,
  input wire logic [rjb_pkg::PC_W-1:0] pc_i,
  input wire logic                     pc_load_o,
  input wire logic [rjb_pkg::PC_W-1:0] pc_target_o,
  input wire logic                     overflow_i,
  input wire logic                     zero_i,
  input wire logic [3:0]               ram_bank_pointer_i,
  input wire logic [rjb_pkg::DA_W-1:0] mem_addr_o,
  input wire logic                     mem_rd_o,
  input wire logic [7:0]               mem_rdata_i,
  input wire logic                     mem_wr_o,
  input wire logic [7:0]               mem_wdata_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // Fields of the accepted word, held until the next accept
  logic [2:0]      b_q;
  logic            a_q;
  logic [7:0]      f_q;
  logic [PC_W-1:0] off_q;
  always_ff @(posedge clk_sys_i)
    if (instr_ack_o)
    begin
      b_q   <= instr_i[11:9];
      a_q   <= instr_i[8];
      f_q   <= instr_i[7:0];
      off_q <= (instr_i[15:11] == OPC_RELATIVE_JUMP) ? {{9{instr_i[10]}}, instr_i[10:0], 1'h0}
                                                     : {{12{instr_i[7]}}, instr_i[7:0], 1'h0};
    end
  property p_quarter; quarter_q1_o |=> (!quarter_q1_o)[*3] ##1 quarter_q1_o; endproperty
  a_quarter: assert property (p_quarter) else $error("Quarter sequence broken");
  property p_nov; instr_ack_o && instr_i[15:8] == OPC_JUMP_IF_NO_OVERFLOW |-> ##3 pc_load_o == !$past(overflow_i);
  endproperty
  a_nov: assert property (p_nov) else $error("No-overflow jump decision wrong");
  property p_nz; instr_ack_o && instr_i[15:8] == OPC_JUMP_IF_NONZERO |-> ##3 pc_load_o == !$past(zero_i); endproperty
  a_nz: assert property (p_nz) else $error("Nonzero jump decision wrong");
  property p_always; instr_ack_o && instr_i[15:11] == OPC_RELATIVE_JUMP |-> ##3 pc_load_o; endproperty
  a_always: assert property (p_always) else $error("Unconditional jump not taken");
  property p_flush; pc_load_o |=> (!instr_ack_o)[*4] ##1 quarter_q1_o; endproperty
  a_flush: assert property (p_flush) else $error("Cycle after jump not idle");
  property p_target; pc_load_o |-> pc_target_o == $past(pc_i) + off_q; endproperty
  a_target: assert property (p_target) else $error("Jump target wrong");
  property p_bitset;
    instr_ack_o && instr_i[15:12] == OPC_SET_SINGLE_BIT |-> ##2 mem_rd_o ##1
      (mem_wr_o && !pc_load_o && mem_wdata_o == ($past(mem_rdata_i) | (8'h01 << b_q)));
  endproperty
  a_bitset: assert property (p_bitset) else $error("Bit set write-back wrong");
  property p_bank; mem_rd_o && a_q |-> mem_addr_o == {$past(ram_bank_pointer_i), f_q}; endproperty
  a_bank: assert property (p_bank) else $error("Banked address wrong");
  property p_access;
    mem_rd_o && !a_q && f_q > INDEXED_MAX_F |-> mem_addr_o == {(f_q[7] ? ACCESS_HI_BNK : ACCESS_LO_BNK), f_q};
  endproperty
  a_access: assert property (p_access) else $error("Access bank address wrong");
endmodule
